// *** core/asgp_pad_if.sv ***
// Purpose: Control and pad bundle between register core and pad mux
// Assumes: One clock domain
// Notes: Pad input here is already synchronised
`timescale 1ns/1ps
interface asgp_pad_if;
  logic [7:0] latch;
  logic [7:0] dir;
  logic [7:0] ana;
  logic [7:0] pad_in_s;
  logic c1_drive;
  logic c2_drive;
  logic c1_res;
  logic c2_res;
  logic ref_on;
  logic [7:0] pad_out;
  logic [7:0] pad_oe_n;
  logic [7:0] dig_in;
  modport core (output latch, dir, ana, pad_in_s, c1_drive, c2_drive, c1_res, c2_res, ref_on,
                input pad_out, pad_oe_n, dig_in);
  modport mux (input latch, dir, ana, pad_in_s, c1_drive, c2_drive, c1_res, c2_res, ref_on,
               output pad_out, pad_oe_n, dig_in);
endinterface

// *** core/asgp_pad_mux.sv ***
// Purpose: Per-pin output, enable and digital-input gating
// Assumes: Controls are registers of the same clock
// Notes: Overrides never reach the direction register
`timescale 1ns/1ps
module asgp_pad_mux (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Core side
  asgp_pad_if.mux pio
);
  logic [7:0] pad_out_ff, nxt_pad_out;
  logic [7:0] pad_oe_n_ff, nxt_pad_oe_n;
  logic [7:0] blk;

  always_comb begin
    nxt_pad_out = pio.latch;
    if (pio.c2_drive) begin
      nxt_pad_out[1] = pio.c2_res;
    end
    if (pio.c1_drive) begin
      nxt_pad_out[2] = pio.c1_res;
    end
    nxt_pad_oe_n = pio.dir;
    blk = pio.ana;
    if (pio.ref_on) begin
      nxt_pad_oe_n[5] = 1'b1;
      blk[5] = 1'b1;
    end
  end

  // Analog or reference pins read as zero
  assign pio.dig_in = pio.pad_in_s & ~blk;
  assign pio.pad_out = pad_out_ff;
  assign pio.pad_oe_n = pad_oe_n_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_out_ff <= 8'h00;
      pad_oe_n_ff <= 8'hFF;
    end else begin
      pad_out_ff <= nxt_pad_out;
      pad_oe_n_ff <= nxt_pad_oe_n;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_OUT_LATCH: assert property (
    ##1 (pio.pad_out[0] == $past(pio.latch[0])) && (pio.pad_out[7:3] == $past(pio.latch[7:3])))
    else $error("pad output does not follow latch");
  AST_OE_DIR: assert property (
    !pio.ref_on |=> pio.pad_oe_n == $past(pio.dir))
    else $error("pad enable does not follow direction");
  AST_CMP_PRIO: assert property (
    pio.c2_drive && pio.c1_drive |=> pio.pad_out[1] == $past(pio.c2_res) && pio.pad_out[2] == $past(pio.c1_res))
    else $error("comparator output lost priority");
  AST_REF_PIN5: assert property (
    pio.ref_on |-> !pio.dig_in[5] ##1 pio.pad_oe_n[5])
    else $error("reference pin still digital");
  AST_DIG_BLOCK: assert property (
    (pio.dig_in & pio.ana) == 8'h00)
    else $error("analog pin passed digital input");

  COV_CMP_DRIVE: cover property (pio.c2_drive && !pio.dir[1] ##1 !pio.pad_oe_n[1]);
  COV_REF_ON: cover property (pio.ref_on && !pio.dir[5] ##1 pio.pad_oe_n[5]);
endmodule

// *** core/asgp_pkg.sv ***
// Purpose: Shared constants for the analog-shared GPIO port
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes: Offsets are byte addresses
package asgp_pkg;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_PIN = 8'h00;
  localparam logic [7:0] OFS_LATCH = 8'h04;
  localparam logic [7:0] OFS_DIR = 8'h08;
  localparam logic [7:0] OFS_ACFG = 8'h0C;
  localparam logic [7:0] OFS_CMPC = 8'h10;
  localparam logic [7:0] OFS_CVR = 8'h14;
  // Reset values
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [5:0] ACFG_RST = 6'h00;
  localparam logic [5:0] CMPC_RST = 6'h07;
  localparam logic [7:0] CVR_RST = 8'h00;
  localparam logic [7:0] ANA_RST = 8'h7F;
  // Field positions
  localparam int ACFG_SEL_LSB = 0;
  localparam int ACFG_VREF_LSB = 4;
  localparam int CMP_MODE_LSB = 0;
  localparam int CMP_C1RES_BIT = 6;
  localparam int CMP_C2RES_BIT = 7;
  localparam int CVR_EN_BIT = 7;
  localparam int CVR_OE_BIT = 6;
  // Comparator modes, channel map and bus response codes
  localparam logic [2:0] CMP_MODE_OFF = 3'h7;
  localparam logic [2:0] CMP_MODE_OUT = 3'h3;
  localparam logic [4:0] CHAN_BASE = 5'h05;
  localparam logic [4:0] SEL_LIMIT = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {ASGP_WR_COLLECT, ASGP_WR_RESP} asgp_wr_t;

  function automatic logic [7:0] asgp_impl_mask(input logic full_pkg);
    asgp_impl_mask = full_pkg ? 8'hFF : 8'hFE;
  endfunction
endpackage

// *** core/asgp_top.sv ***
// Purpose: Eight-pin GPIO port sharing pins with analog functions
// Assumes: AXI4-Lite slave; comparator results and pins are asynchronous
// Notes: One write and one read outstanding; unmapped addresses answer SLVERR
`timescale 1ns/1ps
module asgp_top import asgp_pkg::*; #(
  parameter bit FULL_PKG = 1'b1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe_n,
  output logic [7:0] analog_enable,
  // Analog and serial peripherals
  input wire logic comparator_one_result,
  input wire logic comparator_two_result,
  output logic [5:0] comparator_control_out,
  output logic [7:0] comparator_reference_control_out,
  output logic comparator_reference_output,
  output logic [1:0] adc_vref_select,
  output logic serial_slave_select_input
);
  localparam logic [7:0] IMPL = asgp_impl_mask(FULL_PKG);

  asgp_pad_if pio ();

  // Analog mask: channel ch analog while select < 16 - ch
  function automatic logic [7:0] ana_mask(input logic [3:0] sel, input logic cmp_on);
    logic [4:0] ch;
    ana_mask = 8'h00;
    for (int i = 0; i < 7; i++) begin
      ch = CHAN_BASE + 5'(i);
      ana_mask[i] = ({1'b0, sel} < (SEL_LIMIT - ch));
    end
    if (cmp_on) begin
      ana_mask[6:3] = 4'hF;
    end
  endfunction

  // Synchronisers
  logic [7:0] pin_s1_ff, pin_s2_ff, nxt_pin_s1, nxt_pin_s2;
  logic [1:0] cmp_s1_ff, cmp_s2_ff, nxt_cmp_s1, nxt_cmp_s2;

  always_comb begin
    nxt_pin_s1 = pad_in;
    nxt_pin_s2 = pin_s1_ff;
    nxt_cmp_s1 = {comparator_two_result, comparator_one_result};
    nxt_cmp_s2 = cmp_s1_ff;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_ff <= 8'h00;
      pin_s2_ff <= 8'h00;
      cmp_s1_ff <= 2'h0;
      cmp_s2_ff <= 2'h0;
    end else begin
      pin_s1_ff <= nxt_pin_s1;
      pin_s2_ff <= nxt_pin_s2;
      cmp_s1_ff <= nxt_cmp_s1;
      cmp_s2_ff <= nxt_cmp_s2;
    end
  end

  // Write channel
  asgp_wr_t wr_st_ff, nxt_wr_st;
  logic aw_got_ff, nxt_aw_got;
  logic w_got_ff, nxt_w_got;
  logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
  logic [7:0] wdata_ff, nxt_wdata;
  logic wstrb0_ff, nxt_wstrb0;
  logic [1:0] bresp_ff, nxt_bresp;
  logic wr_do;
  logic wr_hit;

  assign s_axi_awready = (wr_st_ff == ASGP_WR_COLLECT) && !aw_got_ff;
  assign s_axi_wready = (wr_st_ff == ASGP_WR_COLLECT) && !w_got_ff;
  assign s_axi_bvalid = (wr_st_ff == ASGP_WR_RESP);
  assign s_axi_bresp = bresp_ff;
  assign wr_do = (wr_st_ff == ASGP_WR_COLLECT) && aw_got_ff && w_got_ff;

  always_comb begin
    unique case (awaddr_ff)
      OFS_PIN, OFS_LATCH, OFS_DIR, OFS_ACFG, OFS_CMPC, OFS_CVR: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    nxt_wr_st = wr_st_ff;
    nxt_aw_got = aw_got_ff;
    nxt_w_got = w_got_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb0 = wstrb0_ff;
    nxt_bresp = bresp_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_got = 1'b1;
      nxt_wdata = s_axi_wdata[7:0];
      nxt_wstrb0 = s_axi_wstrb[0];
    end
    unique case (wr_st_ff)
      ASGP_WR_COLLECT: begin
        if (wr_do) begin
          nxt_wr_st = ASGP_WR_RESP;
          nxt_aw_got = 1'b0;
          nxt_w_got = 1'b0;
          nxt_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
      end
      ASGP_WR_RESP: begin
        if (s_axi_bready) begin
          nxt_wr_st = ASGP_WR_COLLECT;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_st_ff <= ASGP_WR_COLLECT;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 8'h00;
      wstrb0_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      wr_st_ff <= nxt_wr_st;
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb0_ff <= nxt_wstrb0;
      bresp_ff <= nxt_bresp;
    end
  end

  // Registers and derived pad controls
  logic [7:0] latch_ff, nxt_latch;
  logic [7:0] dir_ff, nxt_dir;
  logic [5:0] acfg_ff, nxt_acfg;
  logic [5:0] cmpc_ff, nxt_cmpc;
  logic [7:0] cvr_ff, nxt_cvr;
  logic [7:0] ana_ff, nxt_ana;
  logic ss_ff, nxt_ss;
  logic cmp_on;
  logic wr_en;

  assign wr_en = wr_do && wstrb0_ff;
  assign cmp_on = (cmpc_ff[CMP_MODE_LSB +: 3] != CMP_MODE_OFF);

  always_comb begin
    nxt_latch = latch_ff;
    nxt_dir = dir_ff;
    nxt_acfg = acfg_ff;
    nxt_cmpc = cmpc_ff;
    nxt_cvr = cvr_ff;
    if (wr_en) begin
      unique case (awaddr_ff)
        OFS_PIN, OFS_LATCH: nxt_latch = wdata_ff & IMPL;
        OFS_DIR: nxt_dir = wdata_ff | ~IMPL;
        OFS_ACFG: nxt_acfg = wdata_ff[5:0];
        OFS_CMPC: nxt_cmpc = wdata_ff[5:0];
        OFS_CVR: nxt_cvr = wdata_ff;
        default: ;
      endcase
    end
    nxt_ana = ana_mask(acfg_ff[ACFG_SEL_LSB +: 4], cmp_on) & IMPL;
    // Pin 7 slave select idles high while it is an output
    nxt_ss = dir_ff[7] ? pin_s2_ff[7] : 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_ff <= LATCH_RST;
      dir_ff <= DIR_RST;
      acfg_ff <= ACFG_RST;
      cmpc_ff <= CMPC_RST;
      cvr_ff <= CVR_RST;
      ana_ff <= ANA_RST & IMPL;
      ss_ff <= 1'b1;
    end else begin
      latch_ff <= nxt_latch;
      dir_ff <= nxt_dir;
      acfg_ff <= nxt_acfg;
      cmpc_ff <= nxt_cmpc;
      cvr_ff <= nxt_cvr;
      ana_ff <= nxt_ana;
      ss_ff <= nxt_ss;
    end
  end

  // Pad mux sees the live analog mask so input blocking is immediate
  assign pio.latch = latch_ff;
  assign pio.dir = dir_ff;
  assign pio.ana = ana_mask(acfg_ff[ACFG_SEL_LSB +: 4], cmp_on) & IMPL;
  assign pio.pad_in_s = pin_s2_ff & IMPL;
  assign pio.c1_drive = (cmpc_ff[CMP_MODE_LSB +: 3] == CMP_MODE_OUT);
  assign pio.c2_drive = (cmpc_ff[CMP_MODE_LSB +: 3] == CMP_MODE_OUT);
  assign pio.c1_res = cmp_s2_ff[0];
  assign pio.c2_res = cmp_s2_ff[1];
  assign pio.ref_on = cvr_ff[CVR_EN_BIT] && cvr_ff[CVR_OE_BIT];

  asgp_pad_mux u_mux (
    .aclk(aclk),
    .aresetn(aresetn),
    .pio(pio)
  );

  assign pad_out = pio.pad_out;
  assign pad_oe_n = pio.pad_oe_n;
  assign analog_enable = ana_ff;
  assign comparator_control_out = cmpc_ff;
  assign comparator_reference_control_out = cvr_ff;
  assign comparator_reference_output = pio.ref_on;
  assign adc_vref_select = acfg_ff[ACFG_VREF_LSB +: 2];
  assign serial_slave_select_input = ss_ff;

  // Read channel
  logic rvalid_ff, nxt_rvalid;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;

  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = {24'h000000, rdata_ff};
  assign s_axi_rresp = rresp_ff;

  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_PIN: nxt_rdata = pio.dig_in;
        OFS_LATCH: nxt_rdata = latch_ff;
        OFS_DIR: nxt_rdata = dir_ff;
        OFS_ACFG: nxt_rdata = {2'h0, acfg_ff};
        OFS_CMPC: nxt_rdata = {cmp_s2_ff[1], cmp_s2_ff[0], cmpc_ff};
        OFS_CVR: nxt_rdata = cvr_ff;
        default: begin
          nxt_rdata = 8'h00;
          nxt_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 8'h00;
      rresp_ff <= RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_RESET_ANALOG: assert property (
    !$past(aresetn) |-> analog_enable[6:1] == 6'h3F && pio.dig_in[6:1] == 6'h00)
    else $error("pins not analog after reset");
  AST_PORT_WR: assert property (
    wr_en && (awaddr_ff == OFS_PIN) |=> latch_ff == ($past(wdata_ff) & IMPL))
    else $error("port write did not load latch");
  AST_LATCH_RD: assert property (
    s_axi_arvalid && s_axi_arready && (s_axi_araddr == OFS_LATCH) && !wr_en
    |=> s_axi_rvalid && s_axi_rdata[7:0] == latch_ff)
    else $error("latch read not latch value");
  AST_DIR_STABLE: assert property (
    !(wr_en && awaddr_ff == OFS_DIR) |=> $stable(dir_ff))
    else $error("direction changed without write");
  AST_CMP_PINS: assert property (
    cmp_on |=> analog_enable[6:3] == 4'hF)
    else $error("comparator pins not analog");
  // First edge after reset still shows the reset idle level
  AST_SS_PIN7: assert property (
    $past(aresetn) && dir_ff[7] && $past(dir_ff[7]) |-> serial_slave_select_input == $past(pin_s2_ff[7]))
    else $error("slave select does not follow pin 7");
  AST_PIN0_GONE: assert property (
    !FULL_PKG |-> !latch_ff[0] && dir_ff[0] && !analog_enable[0])
    else $error("pin 0 present in small package");
  AST_BRESP_TIME: assert property (
    wr_do |=> s_axi_bvalid)
    else $error("write response late");

  COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
  COV_ALL_DIGITAL: cover property (acfg_ff[3:0] == 4'hF && !cmp_on ##1 analog_enable == 8'h00);
endmodule

// *** dv/asgp_pin_model.sv ***
// Purpose: Pins and comparator outputs around the port
// Assumes: Undriven pins take the level the bench asks for
// Notes: A driven pin echoes its own output, as a real pad does
`timescale 1ns/1ps
module asgp_pin_model (
  // From the port
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe_n,
  // Outside world
  input wire logic [7:0] ext_level,
  input wire logic c1_level,
  input wire logic c2_level,
  // To the port
  output logic [7:0] pad_in,
  output logic comparator_one_result,
  output logic comparator_two_result
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_in[i] = pad_oe_n[i] ? ext_level[i] : pad_out[i];
    end
  end
  assign comparator_one_result = c1_level;
  assign comparator_two_result = c2_level;
endmodule

// *** dv/tb_top.sv ***
// Purpose: Register-level test of the analog-shared port
// Assumes: Full package variant, comparators modelled as plain levels
// Notes: Pin effects are sampled a few cycles late for the synchronisers
`timescale 1ns/1ps
module tb_top;
  import asgp_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, c1_res, c2_res, ref_out, ss_in;
  logic [1:0] bresp, rresp, vref_sel;
  logic [31:0] rdata;
  logic [7:0] pad_in, pad_out, pad_oe_n, analog_enable, cfg_out, exp_ana;
  logic [7:0] ext_level = 8'hFF;
  logic c1_level = 1'h0;
  logic c2_level = 1'h0;
  logic [5:0] cmp_out;
  int failures = 0;
  int num_checks = 0;

  always #50 aclk = ~aclk;

  asgp_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .analog_enable(analog_enable),
    .comparator_one_result(c1_res), .comparator_two_result(c2_res), .comparator_control_out(cmp_out),
    .comparator_reference_control_out(cfg_out), .comparator_reference_output(ref_out),
    .adc_vref_select(vref_sel), .serial_slave_select_input(ss_in));

  asgp_pin_model u_pins (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .ext_level(ext_level),
    .c1_level(c1_level), .c2_level(c2_level), .pad_in(pad_in),
    .comparator_one_result(c1_res), .comparator_two_result(c2_res));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic give_up(input int n);
    if (n > 50) begin
      check("bus answer", 32'h0, 32'h1);
      print_verdict();
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Address and data offered together; each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    bit done;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    // Local flag: bready itself only updates after this time step
    while (!done) begin
      @(posedge aclk);
      n++;
      give_up(n);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready) begin
        bready <= 1'h0;
        check("bresp", 32'(bresp), 32'(er));
        done = 1'b1;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
    int n;
    bit done;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!done) begin
      @(posedge aclk);
      n++;
      give_up(n);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready) begin
        rready <= 1'h0;
        check("rdata", rdata, {24'h0, exp});
        check("rresp", 32'(rresp), 32'(er));
        done = 1'b1;
      end
    end
  endtask

  initial begin
    idle(8);
    aresetn <= 1'h1;
    idle(4);
    check("oe reset", 32'(pad_oe_n), 32'hFF);
    check("analog reset", 32'(analog_enable), 32'h7F);
    rd(OFS_PIN, 8'h80, RESP_OKAY);
    rd(OFS_LATCH, LATCH_RST, RESP_OKAY);
    rd(OFS_DIR, DIR_RST, RESP_OKAY);
    rd(OFS_ACFG, 8'h00, RESP_OKAY);
    rd(OFS_CMPC, 8'h07, RESP_OKAY);
    rd(OFS_CVR, 8'h00, RESP_OKAY);
    rd(8'h18, 8'h00, RESP_SLVERR);
    wr(8'h1C, 8'h55, RESP_SLVERR);
    // Software bring-up order: clear latch, comparators off, pins digital
    wr(OFS_PIN, 8'h00, RESP_OKAY);
    wr(OFS_LATCH, 8'h00, RESP_OKAY);
    wr(OFS_CMPC, 8'h07, RESP_OKAY);
    wr(OFS_ACFG, 8'h0F, RESP_OKAY);
    wr(OFS_DIR, 8'hCE, RESP_OKAY);
    idle(4);
    check("analog", 32'(analog_enable), 32'h00);
    check("oe", 32'(pad_oe_n), 32'hCE);
    check("driven", 32'(pad_out & 8'h31), 32'h00);
    ext_level <= 8'hA5;
    wr(OFS_PIN, 8'hFF, RESP_OKAY);
    idle(4);
    check("driven", 32'(pad_out & 8'h31), 32'h31);
    rd(OFS_LATCH, 8'hFF, RESP_OKAY);
    // Lane 0 strobe low: acknowledged but nothing changes
    wstrb <= 4'h0;
    wr(OFS_LATCH, 8'h00, RESP_OKAY);
    wstrb <= 4'hF;
    rd(OFS_LATCH, 8'hFF, RESP_OKAY);
    rd(OFS_PIN, 8'hB5, RESP_OKAY);
    check("slave select", 32'(ss_in), 32'h1);
    ext_level <= 8'h25;
    idle(4);
    check("slave select", 32'(ss_in), 32'h0);
    ext_level <= 8'hA5;
    wr(OFS_LATCH, 8'h10, RESP_OKAY);
    wr(OFS_ACFG, 8'h00, RESP_OKAY);
    idle(4);
    check("driven", 32'(pad_out & 8'h31), 32'h10);
    rd(OFS_PIN, 8'h80, RESP_OKAY);
    check("pin7 analog", 32'(analog_enable[7]), 32'h0);
    for (int s = 0; s < 16; s++) begin
      wr(OFS_ACFG, 8'(s), RESP_OKAY);
      idle(3);
      for (int i = 0; i < 8; i++) exp_ana[i] = (i < 7) && (s < 16 - (5 + i));
      check("channel map", 32'(analog_enable), 32'(exp_ana));
    end
    // Comparator outputs must win over the latch on pins 1 and 2
    wr(OFS_ACFG, 8'hFF, RESP_OKAY);
    rd(OFS_ACFG, 8'h3F, RESP_OKAY);
    wr(OFS_DIR, 8'hC8, RESP_OKAY);
    wr(OFS_LATCH, 8'h02, RESP_OKAY);
    c1_level <= 1'h1;
    wr(OFS_CMPC, 8'h03, RESP_OKAY);
    idle(4);
    check("vref select", 32'(vref_sel), 32'h3);
    check("cmp pins", 32'(pad_out[2:1]), 32'h2);
    check("cmp analog", 32'(analog_enable), 32'h78);
    check("cmp control", 32'(cmp_out), 32'h03);
    rd(OFS_CMPC, 8'h43, RESP_OKAY);
    c1_level <= 1'h0;
    c2_level <= 1'h1;
    idle(4);
    check("cmp pins", 32'(pad_out[2:1]), 32'h1);
    rd(OFS_DIR, 8'hC8, RESP_OKAY);
    // Comparator on without output drive: latch keeps pins 1 and 2
    c2_level <= 1'h0;
    wr(OFS_CMPC, 8'h01, RESP_OKAY);
    idle(4);
    check("latch pins", 32'(pad_out[2:1]), 32'h1);
    check("cmp analog", 32'(analog_enable), 32'h78);
    ext_level <= 8'hFF;
    wr(OFS_CVR, 8'hC0, RESP_OKAY);
    wr(OFS_CMPC, 8'h07, RESP_OKAY);
    idle(4);
    check("ref out", 32'(ref_out), 32'h1);
    check("ref oe", 32'(pad_oe_n[5]), 32'h1);
    check("ref ctl", 32'(cfg_out), 32'hC0);
    rd(OFS_PIN, 8'hCA, RESP_OKAY);
    rd(OFS_DIR, 8'hC8, RESP_OKAY);
    wr(OFS_CVR, 8'h80, RESP_OKAY);
    idle(4);
    check("ref oe", 32'(pad_oe_n[5]), 32'h0);
    print_verdict();
  end
endmodule
